/* File: design/cbl_commission.sv */
// Purpose: Status indicator blinking and commissioning button actions
// Assumes: Single 20 MHz clock, synchronous active-high reset
//          Button pin active low with a pull-up on the board
// Notes: Network actions leave as one-cycle request pulses
//        A software press command during a counting window is dropped
//        Counts saturate at seven presses, which decodes to no action
//        A press wakes a sleeping node even with the button disabled
//
// Summary of operation
// - Enable setting drives indicator pin, default on
// - Blink time from override, zero means 250 ms
// - Enabled indicator blinks while operating
// - Button counted only when enabled, default on
// - Press while asleep wakes for cycle or 30 s
// - One press starts identification broadcast
// - Received identification: fast blink 1 s, frame
// - Two presses nominate coordinator in sync sleep
// - Four presses restore defaults and apply them
// - Software press count runs same action
`timescale 1ns/100ps
module cbl_commission #(
    parameter int WINDOW_TICKS = cbl_pkg::WINDOW_MS,
    parameter int WAKE_TICKS = cbl_pkg::WAKE_MS,
    parameter int TICK_DIV = cbl_pkg::TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic buttonPinN,
    input wire logic seniorToCoord,
    output logic statusLed,
    output logic statusLedOe,
    output logic identBroadcastReq,
    output logic nominateReq,
    output logic restoreApplyReq,
    output logic identFrameReq,
    output logic [7:0] identFrameType,
    output logic coordinatorRole,
    output logic wakeHold
);
    import cbl_pkg::*;

    // Divider and stored settings
    logic [15:0] tickCntReg;
    logic tickReg;
    logic statusEnReg;
    logic buttonEnReg;
    logic syncSleepReg;
    logic framedReg;
    logic asleepReg;
    logic [15:0] blinkOverrideReg;

    // Timers and indicator level
    logic [15:0] blinkCntReg;
    logic [15:0] identCntReg;
    logic [15:0] windowCntReg;
    logic [15:0] wakeCntReg;
    logic ledLevelReg;

    // Press counting and actions
    logic [2:0] pressCntReg;
    logic [2:0] swCountReg;
    logic swReqReg;
    logic pressPulse;
    logic [2:0] lastCountReg;
    cbl_state_t stateReg;

    // Register strobe decode
    logic ctrlWr;
    logic blinkWr;
    logic cmdWr;
    logic cycleEndWr;
    logic identRxWr;

    // Map a completed count to the action it selects
    function automatic logic [2:0] cbl_decode(input logic [2:0] count);
        logic [2:0] act;
        act = 3'b000;
        if (count == PRESS_IDENT) begin
            act = 3'b001;
        end else if (count == PRESS_NOMINATE) begin
            act = 3'b010;
        end else if (count == PRESS_RESTORE) begin
            act = 3'b100;
        end
        return act;
    endfunction : cbl_decode

    // True when a write strobe targets the given register index
    function automatic logic cbl_wr_hit(input logic wr,
        input logic [3:0] addr, input logic [3:0] idx);
        return wr && addr == idx;
    endfunction : cbl_wr_hit

    // Strobe decode shared by the setting and event processes
    assign ctrlWr = cbl_wr_hit(regWr, regAddr, REG_CTRL);
    assign blinkWr = cbl_wr_hit(regWr, regAddr, REG_BLINK);
    assign cmdWr = cbl_wr_hit(regWr, regAddr, REG_PRESS_CMD);
    // Event bits of a control write; neither is stored
    assign cycleEndWr = ctrlWr && regWrData[CTRL_CYCLE_END_BIT];
    assign identRxWr = ctrlWr && regWrData[CTRL_IDENT_RX_BIT];

    // Millisecond enable from the reference clock
    // TICK_DIV must fit the 16-bit divider counter
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tickCntReg <= 16'h0000;
            tickReg <= 1'b0;
        end else if (tickCntReg == 16'(TICK_DIV - 1)) begin
            tickCntReg <= 16'h0000;
            tickReg <= 1'b1;
        end else begin
            tickCntReg <= tickCntReg + 16'h0001;
            tickReg <= 1'b0;
        end
    end

    // One pulse per settled press of the pin
    cbl_debounce #(
        .STABLE_TICKS(DEBOUNCE_MS)
    ) u_debounce (
        .refClk(ref_clk),
        .reset(reset),
        .tick(tickReg),
        .buttonPinN(buttonPinN),
        .pressPulse(pressPulse)
    );

    // Register map, word index on regAddr:
    //   CTRL      [0] indicator enable, [1] button enable, [2] sync sleep,
    //             [3] framed host mode, [4] asleep, [5] write one to end
    //             the sleep cycle, [6] write one for a received identification
    //   BLINK     [15:0] blink half period in ms, zero for the default
    //   PRESS_CMD [2:0] press count run as if pressed, reads as zero
    //   STATUS    [0] indicator level, [2:1] window state, [3] wake hold,
    //             [4] coordinator role, [7:5] last completed count
    //   Other indices read zero and ignore writes

    // Control register writes; a restore puts the defaults back at once
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            statusEnReg <= STATUS_ENABLE_RESET;
            buttonEnReg <= BUTTON_ENABLE_RESET;
            syncSleepReg <= 1'b0;
            framedReg <= 1'b0;
            asleepReg <= 1'b0;
            blinkOverrideReg <= BLINK_OVERRIDE_RESET;
        end else if (restoreApplyReq) begin
            statusEnReg <= STATUS_ENABLE_RESET;
            buttonEnReg <= BUTTON_ENABLE_RESET;
            syncSleepReg <= 1'b0;
            framedReg <= 1'b0;
            asleepReg <= 1'b0;
            blinkOverrideReg <= BLINK_OVERRIDE_RESET;
        end else if (ctrlWr) begin
            statusEnReg <= regWrData[CTRL_STATUS_EN_BIT];
            buttonEnReg <= regWrData[CTRL_BUTTON_EN_BIT];
            syncSleepReg <= regWrData[CTRL_SYNC_SLEEP_BIT];
            framedReg <= regWrData[CTRL_FRAMED_BIT];
            asleepReg <= regWrData[CTRL_ASLEEP_BIT];
        end else if (blinkWr) begin
            blinkOverrideReg <= regWrData[15:0];
        end
    end

    // Software press command stands in for the button
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            swReqReg <= 1'b0;
            swCountReg <= 3'b000;
        end else begin
            swReqReg <= cmdWr;
            swCountReg <= regWrData[2:0];
        end
    end

    // Press counting within the request window
    // Seven is a ceiling, so a long burst decodes to no action
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stateReg <= ST_IDLE;
            pressCntReg <= 3'b000;
            windowCntReg <= 16'h0000;
        end else begin
            unique case (stateReg)
                ST_IDLE: begin
                    if (swReqReg) begin
                        pressCntReg <= swCountReg;
                        stateReg <= ST_ACT;
                    end else if (pressPulse && buttonEnReg) begin
                        pressCntReg <= 3'b001;
                        windowCntReg <= 16'h0000;
                        stateReg <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    // A software command here is dropped; the window rules
                    if (pressPulse && buttonEnReg && pressCntReg != 3'b111)
                    begin
                        pressCntReg <= pressCntReg + 3'b001;
                    end
                    if (tickReg) begin
                        if (windowCntReg == 16'(WINDOW_TICKS - 1)) begin
                            stateReg <= ST_ACT;
                        end else begin
                            windowCntReg <= windowCntReg + 16'h0001;
                        end
                    end
                end
                ST_ACT: begin
                    stateReg <= ST_IDLE;
                end
                default: begin
                    stateReg <= ST_IDLE;
                end
            endcase
        end
    end

    // Action dispatch; unlisted counts do nothing
    // ST_ACT lasts one cycle, so each action pulses once
    always_ff @(posedge ref_clk) begin
        logic [2:0] act;
        act = cbl_decode(pressCntReg);
        if (reset) begin
            identBroadcastReq <= 1'b0;
            nominateReq <= 1'b0;
            restoreApplyReq <= 1'b0;
            lastCountReg <= 3'b000;
        end else begin
            identBroadcastReq <= stateReg == ST_ACT && act[0];
            nominateReq <= stateReg == ST_ACT && act[1]
                && syncSleepReg;
            restoreApplyReq <= stateReg == ST_ACT && act[2];
            if (stateReg == ST_ACT) begin
                lastCountReg <= pressCntReg;
            end
        end
    end

    // Coordinator role taken only when senior
    // A junior node sends the sync message but keeps its place
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            coordinatorRole <= 1'b0;
        end else if (restoreApplyReq) begin
            coordinatorRole <= 1'b0;
        end else if (nominateReq && seniorToCoord) begin
            coordinatorRole <= 1'b1;
        end
    end

    // Wake hold after a press while asleep
    // A press and a cycle end together: the press wins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wakeHold <= 1'b0;
            wakeCntReg <= 16'h0000;
        end else if (pressPulse && asleepReg) begin
            wakeHold <= 1'b1;
            wakeCntReg <= 16'h0000;
        end else if (cycleEndWr) begin
            wakeHold <= 1'b0; // Sleep cycle ended first
        end else if (wakeHold && tickReg) begin
            if (wakeCntReg == 16'(WAKE_TICKS - 1)) begin
                wakeHold <= 1'b0;
            end else begin
                wakeCntReg <= wakeCntReg + 16'h0001;
            end
        end
    end

    // Received identification: one second of fast blink plus frame
    // The frame follows the host mode written beside the event
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            identCntReg <= 16'h0000;
            identFrameReq <= 1'b0;
            identFrameType <= 8'h00;
        end else begin
            identFrameReq <= 1'b0;
            if (identRxWr) begin
                identCntReg <= 16'(IDENT_MS);
                identFrameReq <= regWrData[CTRL_FRAMED_BIT];
                identFrameType <= IDENT_FRAME_TYPE;
            end else if (tickReg && identCntReg != 16'h0000) begin
                identCntReg <= identCntReg - 16'h0001;
            end
        end
    end

    // Blink timing: override or 250 ms default
    // A shorter period applies at once: the compare is >=
    always_ff @(posedge ref_clk) begin
        logic [15:0] period;
        period = (identCntReg != 16'h0000) ? 16'(IDENT_BLINK_MS)
            : (blinkOverrideReg == 16'h0000) ? 16'(BLINK_DEFAULT_MS)
            : blinkOverrideReg;
        if (reset) begin
            blinkCntReg <= 16'h0000;
            ledLevelReg <= 1'b1;
        end else if (tickReg) begin
            if (blinkCntReg >= period - 16'h0001) begin
                blinkCntReg <= 16'h0000;
                ledLevelReg <= ~ledLevelReg;
            end else begin
                blinkCntReg <= blinkCntReg + 16'h0001;
            end
        end
    end

    // Indicator pin driven only when enabled
    // The pin floats, output enable low, while the indicator is off
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            statusLed <= 1'b0;
            statusLedOe <= 1'b0;
        end else begin
            statusLedOe <= statusEnReg;
            statusLed <= statusEnReg && ledLevelReg;
        end
    end

    // Register read port, data one cycle after the strobe
    // Idle cycles return zero, so a late sample sees no stale data
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            regRdData <= 32'h0000_0000;
        end else if (regRd) begin
            unique case (regAddr)
                REG_CTRL: regRdData <= {26'h000_0000, 1'b0, asleepReg,
                    framedReg, syncSleepReg, buttonEnReg, statusEnReg};
                REG_BLINK: regRdData <= {16'h0000, blinkOverrideReg};
                REG_STATUS: regRdData <= {24'h00_0000, lastCountReg,
                    coordinatorRole, wakeHold, stateReg, ledLevelReg};
                default: regRdData <= 32'h0000_0000;
            endcase
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end
endmodule : cbl_commission

/* File: design/cbl_debounce.sv */
// Purpose: Synchronise and debounce the pushbutton pin
// Assumes: Pin is active low, idle high; tick is a 1 ms enable
// Notes: Emits one pulse per settled press
`timescale 1ns/100ps
module cbl_debounce #(
    parameter int STABLE_TICKS = 20
) (
    input wire logic refClk,
    input wire logic reset,
    input wire logic tick,
    input wire logic buttonPinN,
    output logic pressPulse
);
    import cbl_pkg::*;
    logic sync1Reg, sync2Reg, sync3Reg;
    logic stateReg;
    logic [7:0] stableCntReg;
    // Three-stage synchroniser
    always_ff @(posedge refClk) begin
        if (reset) begin
            sync1Reg <= 1'b1;
            sync2Reg <= 1'b1;
            sync3Reg <= 1'b1;
        end else begin
            sync1Reg <= buttonPinN;
            sync2Reg <= sync1Reg;
            sync3Reg <= sync2Reg;
        end
    end
    // Accept a new level after it holds for the debounce time
    always_ff @(posedge refClk) begin
        if (reset) begin
            stateReg <= 1'b1;
            stableCntReg <= 8'h00;
            pressPulse <= 1'b0;
        end else begin
            pressPulse <= 1'b0;
            if (sync2Reg != sync3Reg || sync3Reg == stateReg) begin
                stableCntReg <= 8'h00;
            end else if (tick) begin
                if (stableCntReg == 8'(STABLE_TICKS - 1)) begin
                    stateReg <= sync3Reg;
                    stableCntReg <= 8'h00;
                    pressPulse <= ~sync3Reg; // Falling edge is a press
                end else begin
                    stableCntReg <= stableCntReg + 8'h01;
                end
            end
        end
    end
endmodule : cbl_debounce

/* File: design/cbl_pkg.sv */
// Purpose: Shared constants for the commissioning button and indicator block
// Assumes: 20 MHz reference clock
// Notes: Times are kept in their own unit; cycle counts derive from them
package cbl_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
    localparam int BLINK_DEFAULT_MS = 250;
    localparam int WINDOW_MS = 2000;
    localparam int IDENT_MS = 1000;
    localparam int IDENT_BLINK_MS = 50;
    localparam int WAKE_MS = 30000;
    localparam int DEBOUNCE_MS = 20;
    localparam logic [7:0] IDENT_FRAME_TYPE = 8'h95;
    localparam logic [2:0] PRESS_IDENT = 3'h1;
    localparam logic [2:0] PRESS_NOMINATE = 3'h2;
    localparam logic [2:0] PRESS_RESTORE = 3'h4;
    localparam logic STATUS_ENABLE_RESET = 1'b1;
    localparam logic BUTTON_ENABLE_RESET = 1'b1;
    localparam logic [15:0] BLINK_OVERRIDE_RESET = 16'h0000;
    // Register indices on the plain register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_BLINK = 4'h1;
    localparam logic [3:0] REG_PRESS_CMD = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam int CTRL_STATUS_EN_BIT = 0;
    localparam int CTRL_BUTTON_EN_BIT = 1;
    localparam int CTRL_SYNC_SLEEP_BIT = 2;
    localparam int CTRL_FRAMED_BIT = 3;
    localparam int CTRL_ASLEEP_BIT = 4;
    localparam int CTRL_CYCLE_END_BIT = 5;
    localparam int CTRL_IDENT_RX_BIT = 6;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COUNT = 2'b01,
        ST_ACT = 2'b10
    } cbl_state_t;
endpackage : cbl_pkg

/* File: verif/cbl_button_model.sv */
// Purpose: Pushbutton with contact bounce on the commissioning pin
// Assumes: Pin has a pull-up, so idle and released read high
// Notes: Bounce is far shorter than the debounce time
`timescale 1ns/100ps
module cbl_button_model (
    input wire logic ref_clk,
    output logic buttonPinN
);
    initial buttonPinN = 1'b1;
    // One press: bounce, hold low, bounce back to the pull-up level
    task automatic press(input int lowCycles);
        for (int k = 0; k < 6; k++)
            @(posedge ref_clk) buttonPinN <= k[0];
        @(posedge ref_clk) buttonPinN <= 1'b0;
        repeat (lowCycles) @(posedge ref_clk);
        for (int k = 0; k < 5; k++)
            @(posedge ref_clk) buttonPinN <= !k[0];
    endtask : press
endmodule : cbl_button_model

/* File: verif/cbl_commission_sva.sv */
// Purpose: Port assertions for the commissioning block
// Assumes: Single clock, synchronous active-high reset
// Notes: Bound to every cbl_commission instance
`timescale 1ns/100ps
module cbl_commission_sva
    import cbl_pkg::*;
#(
    parameter int WINDOW_TICKS = 2000,
    parameter int WAKE_TICKS = 30000,
    parameter int TICK_DIV = 20000
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic buttonPinN,
    input wire logic seniorToCoord,
    input wire logic statusLed,
    input wire logic statusLedOe,
    input wire logic identBroadcastReq,
    input wire logic nominateReq,
    input wire logic restoreApplyReq,
    input wire logic identFrameReq,
    input wire logic [7:0] identFrameType,
    input wire logic coordinatorRole,
    input wire logic wakeHold
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    int wakeCnt;
    logic syncBit;
    // Length of the current wake hold
    always_ff @(posedge ref_clk) begin
        if (reset || !wakeHold)
            wakeCnt <= 0;
        else
            wakeCnt <= wakeCnt + 1;
    end
    // Sync sleep setting as last written
    always_ff @(posedge ref_clk) begin
        if (reset || restoreApplyReq)
            syncBit <= 1'b0;
        else if (regWr && regAddr == REG_CTRL)
            syncBit <= regWrData[CTRL_SYNC_SLEEP_BIT];
    end
    rd_idle_a: assert property (!$past(regRd) |-> regRdData == 32'h0000_0000)
        else $error("read data outside the read answer cycle");
    oe_reset_a: assert property ($fell(reset) |-> ##1 statusLedOe)
        else $error("indicator output not enabled after reset");
    oe_clear_a: assert property (regWr && regAddr == REG_CTRL &&
        !regWrData[CTRL_STATUS_EN_BIT] |=> ##[1:2] !statusLedOe)
        else $error("indicator output still enabled");
    wake_bound_a: assert property (
        wakeCnt <= WAKE_TICKS * TICK_DIV + TICK_DIV)
        else $error("wake hold too long");
    ident_pulse_a: assert property (
        identBroadcastReq |=> !identBroadcastReq)
        else $error("broadcast request longer than one cycle");
    nom_sync_a: assert property (nominateReq |-> $past(syncBit))
        else $error("nomination outside sync sleep");
    frame_type_a: assert property (identFrameReq |->
        identFrameType == IDENT_FRAME_TYPE) else $error("wrong frame type");
    frame_rx_a: assert property (regWr && regAddr == REG_CTRL &&
        regWrData[CTRL_IDENT_RX_BIT] && regWrData[CTRL_FRAMED_BIT]
        |-> ##[1:2] identFrameReq) else $error("no identification frame");
    cmd_ident_a: assert property (
        regWr && regAddr == REG_PRESS_CMD && regWrData[2:0] == PRESS_IDENT
        |-> ##[2:4] identBroadcastReq)
        else $error("software press gave no broadcast");
    restore_role_a: assert property (restoreApplyReq |->
        ##[1:2] !coordinatorRole) else $error("role kept after restore");
    // Main scenarios reached
    cover property (nominateReq ##[1:2] coordinatorRole);
    cover property (restoreApplyReq);
    cover property ($rose(wakeHold));
endmodule : cbl_commission_sva

bind cbl_commission cbl_commission_sva #(.WINDOW_TICKS(WINDOW_TICKS),
    .WAKE_TICKS(WAKE_TICKS), .TICK_DIV(TICK_DIV)) i_cbl_commission_sva (.*);

/* File: verif/cbl_commission_tb.sv */
// Purpose: Self-checking bench for the commissioning block
// Assumes: Short tick of 4 cycles, window 200 ticks, wake 20 ticks
// Notes: Expected pulse counts come from a press-count model
`timescale 1ns/100ps
module cbl_commission_tb;
    import cbl_pkg::*;
    logic ref_clk = 1'b0;
    logic reset;
    logic [3:0] regAddr;
    logic [31:0] regWrData;
    logic regWr;
    logic regRd;
    logic seniorToCoord;
    logic [31:0] regRdData, blink;
    logic buttonPinN, statusLed, statusLedOe, identBroadcastReq, nominateReq;
    logic restoreApplyReq, identFrameReq, coordinatorRole, wakeHold;
    logic [7:0] identFrameType;
    int n_fail = 0;
    int tests_run = 0;
    int nIdent = 0, nNom = 0, nRest = 0, nFrame = 0, nToggle = 0, t0;
    int expIdent = 0, expNom = 0;
    always #25 ref_clk = ~ref_clk;
    cbl_commission #(.WINDOW_TICKS(200), .WAKE_TICKS(20), .TICK_DIV(4))
    i_cbl_commission (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .buttonPinN(buttonPinN),
        .seniorToCoord(seniorToCoord), .statusLed(statusLed),
        .statusLedOe(statusLedOe), .identBroadcastReq(identBroadcastReq),
        .nominateReq(nominateReq), .restoreApplyReq(restoreApplyReq),
        .identFrameReq(identFrameReq), .identFrameType(identFrameType),
        .coordinatorRole(coordinatorRole), .wakeHold(wakeHold));
    cbl_button_model i_cbl_button_model (.ref_clk(ref_clk),
        .buttonPinN(buttonPinN));
    // Count action pulses and indicator edges
    always @(posedge ref_clk) begin
        if (identBroadcastReq === 1'b1) nIdent++;
        if (nominateReq === 1'b1) nNom++;
        if (restoreApplyReq === 1'b1) nRest++;
        if (identFrameReq === 1'b1) nFrame++;
    end
    always @(statusLed) nToggle++;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 chk(regRdData, exp);
    endtask : rd
    // Bounded wait for a pulse count; running out ends the run
    task automatic waitFor(ref int cnt, input int exp);
        for (int k = 0; k < 2000 && cnt != exp; k++) @(posedge ref_clk);
        chk(cnt, exp);
        if (cnt != exp) print_verdict();
    endtask : waitFor
    // Count indicator edges over a span after letting it settle
    task automatic blinks(input int settle, input int span, input int exp);
        repeat (settle) @(posedge ref_clk);
        #1 t0 = nToggle;
        repeat (span) @(posedge ref_clk);
        #1 chk(nToggle - t0, exp);
    endtask : blinks
    initial begin
        reset <= 1'b1;
        regAddr <= 4'h0;
        regWrData <= 32'h0000_0000;
        regWr <= 1'b0;
        regRd <= 1'b0;
        seniorToCoord <= 1'b1;
        t0 = $urandom(90173);
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        rd(REG_CTRL, 32'h0000_0003);
        chk({31'h0, statusLedOe}, 32'h1);
        rd(4'hF, 32'h0000_0000);
        rd(REG_PRESS_CMD, 32'h0000_0000);
        blink = 1 + ($urandom % 8);
        wr(REG_BLINK, blink);
        rd(REG_BLINK, blink);
        blinks(blink * 8 + 8, blink * 40, 10);
        wr(REG_BLINK, 32'h0000_0000);
        blinks(1100, 2000, 2);
        wr(REG_CTRL, 32'h0000_0002);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, statusLedOe}, 32'h0);
        // Software presses, every count, sync sleep and seniority on
        wr(REG_CTRL, 32'h0000_0007);
        for (int c = 0; c < 8; c++) begin
            wr(REG_PRESS_CMD, c);
            repeat (8) @(posedge ref_clk);
            expIdent += int'(c == 1);
            expNom += int'(c == 2);
            if (c == 2) chk({31'h0, coordinatorRole}, 32'h1);
        end
        chk(nIdent, expIdent);
        chk(nNom, expNom);
        chk(nRest, 1);
        chk({31'h0, coordinatorRole}, 32'h0);
        rd(REG_CTRL, 32'h0000_0003);
        // Junior node nominates but takes no role; no sync, no nomination
        @(posedge ref_clk);
        seniorToCoord <= 1'b0;
        wr(REG_CTRL, 32'h0000_0007);
        wr(REG_PRESS_CMD, 32'h0000_0002);
        wr(REG_CTRL, 32'h0000_0003);
        wr(REG_PRESS_CMD, 32'h0000_0002);
        repeat (8) @(posedge ref_clk);
        chk(nNom, expNom + 1);
        chk({31'h0, coordinatorRole}, 32'h0);
        // Button presses, one in a window of its own, then four inside one window
        i_cbl_button_model.press(100);
        waitFor(nIdent, expIdent + 1);
        for (int p = 0; p < 4; p++) begin
            i_cbl_button_model.press(100);
            repeat (120) @(posedge ref_clk); // Release settles
        end
        waitFor(nRest, 2);
        chk(nIdent, expIdent + 1);
        wr(REG_CTRL, 32'h0000_0001);
        i_cbl_button_model.press(100);
        repeat (1200) @(posedge ref_clk);
        chk(nIdent, expIdent + 1);
        // Press while asleep wakes; cycle end drops the hold
        wr(REG_CTRL, 32'h0000_0011);
        i_cbl_button_model.press(90);
        chk({31'h0, wakeHold}, 32'h1);
        wr(REG_CTRL, 32'h0000_0031);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, wakeHold}, 32'h0);
        // Identification received, framed then plain
        wr(REG_CTRL, 32'h0000_004B);
        repeat (3) @(posedge ref_clk);
        chk(nFrame, 1);
        chk({24'h0, identFrameType}, {24'h0, IDENT_FRAME_TYPE});
        blinks(20, 800, 4);
        wr(REG_CTRL, 32'h0000_0043);
        repeat (3) @(posedge ref_clk);
        chk(nFrame, 1);
        print_verdict();
    end
endmodule : cbl_commission_tb
